// ==== hw/fct_pkg.sv ====
// Constants, types and register map of the far-end code channel transmitter
package fct_pkg;
   // Register byte addresses
   localparam logic [7:0]  FCT_CODE_BYTE_IDX = 8'h03;
   localparam logic [11:0] FCT_ADDR_CODE     = 12'h00c;
   localparam logic [11:0] FCT_ADDR_MODE     = 12'h040;
   localparam logic [11:0] FCT_ADDR_STATUS   = 12'h044;
   localparam logic [11:0] FCT_ADDR_MASK     = 12'h048;
   // Reset values, codeword flag and last bit index
   localparam logic [7:0]  FCT_CODE_RST      = 8'hff;
   localparam logic [4:0]  FCT_MODE_RST      = 5'h00;
   localparam logic [15:0] FCT_IDLE_WORD     = 16'hffff;
   localparam logic [7:0]  FCT_FLAG          = 8'hff;
   localparam logic [3:0]  FCT_WORD_LAST     = 4'hf;
   // Mode register fields
   localparam int FCT_MODE_CBP = 0;
   localparam int FCT_MODE_E3  = 1;
   localparam int FCT_MODE_EXT = 2;
   localparam int FCT_MODE_ALM = 3;
   // Status bit position
   localparam int FCT_ST_CODE  = 0;

   // Alarm output selections
   typedef enum logic [1:0] {
      FCT_ALM_NONE   = 2'b00,
      FCT_ALM_YELLOW = 2'b01,
      FCT_ALM_AIS    = 2'b10,
      FCT_ALM_ONES   = 2'b11
   } fct_alarm_t;

   // Mode control bits
   typedef struct packed {
      fct_alarm_t alarm_output_select;
      logic       external_cbit_insert;
      logic       e3_framing_select;
      logic       cbit_parity_link_enable;
   } fct_mode_t;

   // Overhead slot interface towards the framer
   typedef struct packed {
      logic m_frame_start;
      logic cbit_slot;
   } fct_slot_t;
endpackage

// ==== hw/fct_serializer.sv ====
// Codeword serializer, one bit per channel slot
`timescale 1ns/1ps
`default_nettype none
module fct_serializer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slot_en,
   input  wire logic        word_ok,
   input  wire logic [7:0]  word_byte,
   output logic             bit_out,
   output logic             word_done
);
   import fct_pkg::*;

   typedef struct packed {
      logic [15:0] sh;
      logic [3:0]  cnt;
   } fct_ser_state_t;

   fct_ser_state_t q, d;

   // Shift on each slot; load a fresh codeword after the last bit
   always_comb begin
      d = q;
      word_done = 1'b0;
      if (slot_en) begin
         d.sh  = {1'b1, q.sh[15:1]};
         d.cnt = q.cnt + 4'h1;
         if (q.cnt == FCT_WORD_LAST) begin
            word_done = 1'b1;
            d.sh = word_ok ? {word_byte, FCT_FLAG} : FCT_IDLE_WORD;
         end
      end
   end
   assign bit_out = q.sh[0];

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{sh: FCT_IDLE_WORD, cnt: 4'h0};
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// ==== hw/fct_transmitter.sv ====
// Far-end code channel transmitter with APB registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fct_transmitter (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire fct_pkg::fct_slot_t slot,
   output logic                   feac_bit,
   output logic                   feac_bit_valid,
   output logic                   link_irq_n
);
   import fct_pkg::*;

   typedef struct packed {
      logic [7:0]  code;
      logic        pend;
      fct_mode_t   mode;
      logic        status;
      logic        mask;
      logic        sf1;
      logic [1:0]  ccnt;
      logic [31:0] rdata;
      logic        rdy;
      logic        err;
      logic        bit_o;
      logic        bit_v;
      logic        irq_n;
   } fct_state_t;

   fct_state_t q, d;
   logic       wr, rd, hit, slot_en, chan_on, code_ok, done, ser_bit;

   // APB access decode, one wait state
   assign wr  = psel & penable & pwrite & ~q.rdy;
   assign rd  = psel & penable & ~pwrite & ~q.rdy;
   assign hit = paddr == FCT_ADDR_CODE || paddr == FCT_ADDR_MODE ||
                paddr == FCT_ADDR_STATUS || paddr == FCT_ADDR_MASK;

   // Channel gating by framing mode and alarm selection
   assign chan_on = q.mode.cbit_parity_link_enable & ~q.mode.e3_framing_select
                  & (q.mode.alarm_output_select != FCT_ALM_AIS)
                  & (q.mode.alarm_output_select != FCT_ALM_ONES);
   assign code_ok = ~q.code[7] & ~q.code[0];
   // Third C-bit of subframe one
   assign slot_en = slot.cbit_slot & q.sf1 & (q.ccnt == 2'd2);

   fct_serializer u_ser (
      .pclk      (pclk),
      .presetn   (presetn),
      .slot_en   (slot_en),
      .word_ok   (q.pend & code_ok),
      .word_byte (q.code),
      .bit_out   (ser_bit),
      .word_done (done)
   );

   // Next-state logic for registers, slot tracking and outputs
   always_comb begin
      d = q;
      d.rdy = psel & penable & ~q.rdy;
      d.err = psel & penable & ~q.rdy & ~hit;
      // Slot position: first C-bits after M-frame start are subframe one
      if (slot.m_frame_start) begin
         d.sf1  = 1'b1;
         d.ccnt = 2'd0;
      end else if (slot.cbit_slot) begin
         if (q.ccnt == 2'd2) begin
            d.sf1  = 1'b0;
         end else begin
            d.ccnt = q.ccnt + 2'd1;
         end
      end
      // Buffer consumed at codeword load unless rewritten
      if (done) begin
         d.pend = 1'b0;
      end
      if (wr && paddr == FCT_ADDR_CODE && pstrb[0]) begin
         d.code = pwdata[7:0];
         d.pend = 1'b1;
         d.status = 1'b0;
      end
      if (wr && paddr == FCT_ADDR_MODE && pstrb[0]) begin
         d.mode = fct_mode_t'(pwdata[4:0]);
      end
      if (wr && paddr == FCT_ADDR_MASK && pstrb[0]) begin
         d.mask = pwdata[FCT_ST_CODE];
      end
      // Buffer taken by serializer: request next byte; set beats clear
      if (done && q.pend && code_ok && chan_on) begin
         d.status = 1'b1;
      end
      d.rdata = 32'h0;
      if (rd) begin
         case (paddr)
            FCT_ADDR_CODE:   d.rdata = {24'h0, q.code};
            FCT_ADDR_MODE:   d.rdata = {27'h0, q.mode};
            FCT_ADDR_STATUS: d.rdata = {31'h0, q.status};
            FCT_ADDR_MASK:   d.rdata = {31'h0, q.mask};
            default:         d.rdata = 32'h0;
         endcase
      end
      d.bit_o = chan_on ? ser_bit : 1'b1;
      d.bit_v = slot_en & chan_on;
      d.irq_n = ~(q.status & q.mask & q.mode.cbit_parity_link_enable);
   end

   // State register: all fields load their next values every clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{code: FCT_CODE_RST, pend: 1'b0, mode: fct_mode_t'(FCT_MODE_RST),
                status: 1'b0, mask: 1'b1, sf1: 1'b0, ccnt: 2'd0, rdata: 32'h0,
                rdy: 1'b0, err: 1'b0, bit_o: 1'b1, bit_v: 1'b0, irq_n: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign prdata         = q.rdata;
   assign pready         = q.rdy;
   assign pslverr        = q.err;
   assign feac_bit       = q.bit_o;
   assign feac_bit_valid = q.bit_v;
   assign link_irq_n     = q.irq_n;
endmodule
`default_nettype wire

// ==== tb/fct_frame_model.sv ====
// Framer overhead strobe model
`timescale 1ns/1ps
`default_nettype none
module fct_frame_model (
   input  wire logic   pclk,
   input  wire logic   presetn,
   output fct_pkg::fct_slot_t slot
);
   import fct_pkg::*;
   logic [4:0] pos_q;
   // Frame position, 24 cycles per M-frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pos_q <= 5'h0;
      else pos_q <= (pos_q == 5'h17) ? 5'h0 : pos_q + 5'h1;
   end
   // Start strobe, then five C-bit strobes; third is the channel
   assign slot.m_frame_start = presetn && pos_q == 5'h0;
   assign slot.cbit_slot = presetn && pos_q[1:0] == 2'h0 && pos_q != 5'h0;
endmodule
`default_nettype wire

// ==== tb/fct_transmitter_sva.sv ====
// Port checker for the code channel transmitter
`timescale 1ns/1ps
`default_nettype none
module fct_transmitter_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire fct_pkg::fct_slot_t slot,
   input wire logic        feac_bit_valid,
   input wire logic        link_irq_n
);
   import fct_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access waiting, and interrupt with the bus quiet
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_quiet; !link_irq_n && !psel && !$past(psel); endsequence
   AST_RDY: assert property (s_wait |=> pready) else $error("late ready");
   AST_RDY_PULSE: assert property (pready |=> !pready) else $error("long ready");
   AST_RDY_REQ: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
   AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
   AST_ERR_DATA: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
   AST_VLD_PULSE: assert property (feac_bit_valid |=> !feac_bit_valid) else $error("long valid");
   AST_VLD_SLOT: assert property (feac_bit_valid |-> $past(slot.cbit_slot)) else $error("no slot");
   AST_IRQ_HOLD: assert property (s_quiet |=> !link_irq_n) else $error("irq dropped");
endmodule
bind fct_transmitter fct_transmitter_sva sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slot(slot),
   .feac_bit_valid(feac_bit_valid), .link_irq_n(link_irq_n));
`default_nettype wire

// ==== tb/fct_transmitter_test.sv ====
// Self-checking bench for the code channel transmitter
`timescale 1ns/1ps
`default_nettype none
module fct_transmitter_test;
   import fct_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr, pready, pslverr;
   logic feac_bit, feac_bit_valid, link_irq_n;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [15:0] word;
   logic [7:0]  b1, b2;
   fct_slot_t   slot;
   int          error_cnt = 0, compares = 0, seed = 32'h8327a679;
   always #20 pclk = ~pclk;
   fct_frame_model frm (.pclk(pclk), .presetn(presetn), .slot(slot));
   fct_transmitter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slot(slot), .feac_bit(feac_bit),
      .feac_bit_valid(feac_bit_valid), .link_irq_n(link_irq_n));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Collect one codeword, first bit lowest
   task automatic grab();
      for (int i = 0; i < 16; i++) begin
         do @(posedge pclk); while (feac_bit_valid !== 1'b1);
         word[i] = feac_bit;
      end
   endtask
   // Set the mode, then count channel bits over four M-frames
   task automatic vld_cnt(input logic [7:0] m, input int exp);
      int n;
      n = 0;
      apb(1, FCT_ADDR_MODE, {24'h0, m});
      repeat (96) begin
         @(posedge pclk);
         if (feac_bit_valid === 1'b1) begin
            n++;
         end
      end
      chk(32'(n), 32'(exp));
   endtask
   // Expected codeword: flag then byte
   function automatic logic [31:0] cw(input logic [7:0] b);
      return {16'h0, b, FCT_FLAG};
   endfunction
   task automatic tally_and_finish();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Watchdog
   initial begin
      #800000;
      error_cnt++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      b1 = 8'($random(seed)) & 8'h7e;
      b2 = 8'($random(seed)) & 8'h7e;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, FCT_ADDR_CODE, 32'h0);
      chk(rdata, {24'h0, FCT_CODE_RST});
      apb(0, 12'h0f0, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdata, 32'h0);
      apb(1, FCT_ADDR_MODE, 32'h0d);
      apb(1, FCT_ADDR_MASK, 32'h1);
      apb(1, FCT_ADDR_CODE, {24'h0, b1});
      wait (link_irq_n === 1'b0);
      apb(1, FCT_ADDR_CODE, {24'h0, b2});
      grab();
      chk({16'h0, word}, cw(b1));
      wait (link_irq_n === 1'b0);
      grab();
      chk({16'h0, word}, cw(b2));
      grab();
      chk({16'h0, word}, 32'hffff);
      apb(0, FCT_ADDR_STATUS, 32'h0);
      chk(rdata, 32'h1);
      apb(1, FCT_ADDR_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'(link_irq_n), 32'h1);
      apb(1, FCT_ADDR_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(link_irq_n), 32'h0);
      apb(1, FCT_ADDR_MODE, 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'(link_irq_n), 32'h1);
      apb(1, FCT_ADDR_MODE, 32'h0d);
      apb(1, FCT_ADDR_CODE, 32'h81);
      repeat (2) @(posedge pclk);
      chk(32'(link_irq_n), 32'h1);
      grab();
      grab();
      chk({16'h0, word}, 32'hffff);
      chk(32'(link_irq_n), 32'h1);
      vld_cnt(8'h11, 0);
      vld_cnt(8'h19, 0);
      vld_cnt(8'h03, 0);
      vld_cnt(8'h00, 0);
      vld_cnt(8'h0d, 4);
      // Reset in mid-run: outputs idle, registers back to reset values
      apb(1, FCT_ADDR_MASK, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({30'h0, feac_bit_valid, pready}, 32'h0);
      chk(32'(link_irq_n), 32'h1);
      presetn <= 1'b1;
      apb(0, FCT_ADDR_MODE, 32'h0);
      chk(rdata, 32'(FCT_MODE_RST));
      apb(0, FCT_ADDR_MASK, 32'h0);
      chk(rdata, 32'h1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
